// *** hdl/uic_cfg.svh ***
`ifndef UIC_CFG_SVH
`define UIC_CFG_SVH
// ========================================
// Register indices.
`define UIC_IDX_DATA 4'h0
`define UIC_IDX_LINE 4'h1
`define UIC_IDX_CTRL 4'h2
`define UIC_IDX_IBRD 4'h3
`define UIC_IDX_FBRD 4'h4
`define UIC_IDX_IMSC 4'h5
`define UIC_IDX_RIS 4'h6
`define UIC_IDX_MIS 4'h7
`define UIC_IDX_ICR 4'h8
`define UIC_IDX_DMACR 4'h9
`define UIC_IDX_LPDIV 4'hA
`define UIC_IDX_FLAG 4'hB
// ========================================
// Interrupt bit positions.
`define UIC_B_OE 10
`define UIC_B_BE 9
`define UIC_B_PE 8
`define UIC_B_FE 7
`define UIC_B_RT 6
`define UIC_B_TX 5
`define UIC_B_RX 4
// Line control and control bit positions.
`define UIC_L_FEN 4
`define UIC_L_STP2 3
`define UIC_L_EPS 2
`define UIC_L_PEN 1
`define UIC_L_BRK 0
`define UIC_C_EN 0
`define UIC_C_TXE 8
`define UIC_C_RXE 9
// DMA control bit positions.
`define UIC_D_ONERR 2
`define UIC_D_TXE 1
`define UIC_D_RXE 0
// ========================================
// Counts and reset values.
`define UIC_TIMEOUT 9'h1FF
`define UIC_RX_WATER 6'h04
`define UIC_TX_WATER 6'h04
`define UIC_IRQ_RESET 11'h000
`endif

// *** hdl/uic_pkg.sv ***
package uic_pkg;
	typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR,
		TX_STOP} uic_tx_t;
	typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR,
		RX_STOP} uic_rx_t;
endpackage

// *** hdl/uic_core.sv ***
`timescale 1ns/100ps
`include "uic_cfg.svh"
// ========================================
// FIFO with valid and ready on both sides.
module uic_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 32,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic oneDeep,
	input wire logic inValid,
	input wire logic [W-1:0] inData,
	output logic inReady,
	output logic outValid,
	output logic [W-1:0] outData,
	input wire logic outReady,
	output logic [CW-1:0] count
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic push, pop;
	// Disabled mode limits the buffer to one entry.
	always_comb begin
		inReady = cnt_q < (oneDeep ? CW'(1) : CW'(DEPTH));
		outValid = cnt_q != '0;
		outData = mem[rdPtr_q];
		count = cnt_q;
		push = inValid && inReady;
		pop = outValid && outReady;
		wrPtr_d = push ? wrPtr_q + 1'b1 : wrPtr_q;
		rdPtr_d = pop ? rdPtr_q + 1'b1 : rdPtr_q;
		cnt_d = cnt_q + CW'(push) - CW'(pop);
	end
	// Pointer and count registers.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr_q <= '0;
			rdPtr_q <= '0;
			cnt_q <= '0;
		end else begin
			wrPtr_q <= wrPtr_d;
			rdPtr_q <= rdPtr_d;
			cnt_q <= cnt_d;
		end
	end
	// Storage has no reset.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wrPtr_q] <= inData;
		end
	end
endmodule

// ========================================
// Serial transceiver core.
module uic_core #(
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [3:0] regIdx,
	input wire logic regWrite,
	input wire logic regRead,
	input wire logic [31:0] regWdata,
	output logic [31:0] regRdata,
	input wire logic rxd,
	output logic txd,
	input wire logic [3:0] modemIn,
	output logic combined_irq_output,
	output logic rx_dma_single_request,
	output logic rx_dma_burst_request,
	output logic txDmaSingleRequest,
	output logic txDmaBurstRequest,
	output logic infrared_lowpower_tick
);
	localparam int CW = $clog2(DEPTH + 1);
	// Register state.
	logic [7:0] line_q, line_d;
	logic [9:0] ctrl_q, ctrl_d;
	logic [15:0] divisor_integer_part_q, divisor_integer_part_d;
	logic [5:0] divisor_fraction_part_q, divisor_fraction_part_d;
	logic [10:0] imsc_q, imsc_d, ris_q, ris_d;
	logic [2:0] dmacr_q, dmacr_d;
	logic [7:0] lpDiv_q, lpDiv_d, lpCnt_q, lpCnt_d;
	logic [31:0] rdata_d;
	logic irq_d, rxS_d, rxB_d, txS_d, txB_d, lpTick_d;
	// Baud generator state.
	logic [15:0] baudCnt_q, baudCnt_d;
	logic [5:0] fracAcc_q, fracAcc_d;
	logic tick_q, tick_d;
	// Pin synchronisers: three stages, change once stages two and three agree.
	logic [4:0] s1_q, s2_q, s3_q, filt_q, filt_d;
	logic rxF;
	// Transmit path.
	uic_pkg::uic_tx_t txSt_q, txSt_d;
	logic [3:0] txTk_q, txTk_d;
	logic [2:0] txBit_q, txBit_d;
	logic [7:0] txSh_q, txSh_d;
	logic txStop2_q, txStop2_d, txd_d;
	logic txInValid, txInReady, txOutValid, txPop;
	logic [7:0] txOutData;
	logic [CW-1:0] txCount;
	// Receive path.
	uic_pkg::uic_rx_t rxSt_q, rxSt_d;
	logic [3:0] rxTk_q, rxTk_d;
	logic [2:0] rxBit_q, rxBit_d;
	logic [7:0] rxSh_q, rxSh_d;
	logic rxPe_q, rxPe_d, ovrPend_q, ovrPend_d;
	logic rxArm_q, rxArm_d;
	logic [8:0] rtCnt_q, rtCnt_d;
	logic rxPush, rxInReady, rxOutValid, rxPop, rxOk;
	logic [11:0] rxEntry, rxOutData;
	logic [CW-1:0] rxCount;
	logic wrHit, rdHit, fen, lineTick;

	// Transmit buffer: data writes fill, serializer drains.
	uic_fifo #(.W(8), .DEPTH(DEPTH)) txFifo (
		.clk(clk), .reset_n(reset_n), .oneDeep(!fen),
		.inValid(txInValid), .inData(regWdata[7:0]), .inReady(txInReady),
		.outValid(txOutValid), .outData(txOutData), .outReady(txPop),
		.count(txCount)
	);
	// Receive buffer: deserializer fills, data reads drain.
	uic_fifo #(.W(12), .DEPTH(DEPTH)) rxFifo (
		.clk(clk), .reset_n(reset_n), .oneDeep(!fen),
		.inValid(rxPush), .inData(rxEntry), .inReady(rxInReady),
		.outValid(rxOutValid), .outData(rxOutData), .outReady(rxPop),
		.count(rxCount)
	);

	// Register port decode, status flags and request outputs.
	always_comb begin
		fen = line_q[`UIC_L_FEN];
		wrHit = regWrite;
		rdHit = regRead;
		txInValid = wrHit && regIdx == `UIC_IDX_DATA;
		rxPop = rdHit && regIdx == `UIC_IDX_DATA;
		line_d = line_q;
		ctrl_d = ctrl_q;
		divisor_integer_part_d = divisor_integer_part_q;
		divisor_fraction_part_d = divisor_fraction_part_q;
		imsc_d = imsc_q;
		dmacr_d = dmacr_q;
		lpDiv_d = lpDiv_q;
		ris_d = ris_q;
		if (wrHit) begin
			case (regIdx)
				`UIC_IDX_LINE: line_d = regWdata[7:0];
				`UIC_IDX_CTRL: ctrl_d = regWdata[9:0];
				`UIC_IDX_IBRD: divisor_integer_part_d = regWdata[15:0];
				`UIC_IDX_FBRD: divisor_fraction_part_d = regWdata[5:0];
				`UIC_IDX_IMSC: imsc_d = regWdata[10:0];
				`UIC_IDX_ICR: ris_d = ris_q & ~regWdata[10:0];
				`UIC_IDX_DMACR: dmacr_d = regWdata[2:0];
				`UIC_IDX_LPDIV: lpDiv_d = regWdata[7:0];
				default: ;
			endcase
		end
		// Sources set after clears so a set in the same cycle wins.
		if (txInValid) begin
			ris_d[`UIC_B_TX] = 1'b0;
		end
		if (txPop && txCount == CW'(1)) begin
			ris_d[`UIC_B_TX] = 1'b1;
		end
		if (rxPush) begin
			ris_d[`UIC_B_RX] = 1'b1;
			// A character that finds the buffer full flags overrun at once.
			ris_d[`UIC_B_OE] = ris_d[`UIC_B_OE] | rxEntry[11] | !rxInReady;
			ris_d[`UIC_B_BE] = ris_d[`UIC_B_BE] | rxEntry[10];
			ris_d[`UIC_B_PE] = ris_d[`UIC_B_PE] | rxEntry[9];
			ris_d[`UIC_B_FE] = ris_d[`UIC_B_FE] | rxEntry[8];
		end
		if (rxCount != '0 && rtCnt_q == `UIC_TIMEOUT) begin
			ris_d[`UIC_B_RT] = 1'b1;
		end
		ris_d[3:0] = ris_d[3:0] | (filt_d[3:0] ^ filt_q[3:0]);
		case (regIdx)
			`UIC_IDX_DATA: rdata_d = {20'h00000, rxOutData};
			`UIC_IDX_LINE: rdata_d = {24'h000000, line_q};
			`UIC_IDX_CTRL: rdata_d = {22'h000000, ctrl_q};
			`UIC_IDX_IBRD: rdata_d = {16'h0000, divisor_integer_part_q};
			`UIC_IDX_FBRD: rdata_d = {26'h0000000, divisor_fraction_part_q};
			`UIC_IDX_IMSC: rdata_d = {21'h000000, imsc_q};
			`UIC_IDX_RIS: rdata_d = {21'h000000, ris_q};
			`UIC_IDX_MIS: rdata_d = {21'h000000, ris_q & imsc_q};
			`UIC_IDX_DMACR: rdata_d = {29'h00000000, dmacr_q};
			`UIC_IDX_LPDIV: rdata_d = {24'h000000, lpDiv_q};
			`UIC_IDX_FLAG: rdata_d = {26'h0000000, txSt_q != uic_pkg::TX_IDLE,
				!rxOutValid, !txInReady, rxInReady, txCount == '0, 1'b0};
			default: rdata_d = 32'h00000000;
		endcase
		if (!rdHit) begin
			rdata_d = regRdata;
		end
		irq_d = |(ris_q & imsc_q);
		rxOk = dmacr_q[`UIC_D_RXE] && !(dmacr_q[`UIC_D_ONERR] &&
			|ris_q[`UIC_B_OE:`UIC_B_FE]);
		rxS_d = rxOk && rxOutValid;
		rxB_d = rxOk && rxCount >= CW'(`UIC_RX_WATER);
		txS_d = dmacr_q[`UIC_D_TXE] && txInReady;
		txB_d = dmacr_q[`UIC_D_TXE] && (CW'(DEPTH) - txCount) >=
			CW'(`UIC_TX_WATER) && fen;
		// Low-power tick divides the clock by the low-power divisor plus one.
		lpTick_d = lpCnt_q == 8'h00;
		lpCnt_d = lpTick_d ? lpDiv_q : lpCnt_q - 8'h01;
	end
	// Register file and output registers.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			line_q <= 8'h00;
			ctrl_q <= 10'h000;
			divisor_integer_part_q <= 16'h0001;
			divisor_fraction_part_q <= 6'h00;
			imsc_q <= `UIC_IRQ_RESET;
			ris_q <= `UIC_IRQ_RESET;
			dmacr_q <= 3'h0;
			lpDiv_q <= 8'h00;
			lpCnt_q <= 8'h00;
			regRdata <= 32'h00000000;
			combined_irq_output <= 1'b0;
			rx_dma_single_request <= 1'b0;
			rx_dma_burst_request <= 1'b0;
			txDmaSingleRequest <= 1'b0;
			txDmaBurstRequest <= 1'b0;
			infrared_lowpower_tick <= 1'b0;
		end else begin
			line_q <= line_d;
			ctrl_q <= ctrl_d;
			divisor_integer_part_q <= divisor_integer_part_d;
			divisor_fraction_part_q <= divisor_fraction_part_d;
			imsc_q <= imsc_d;
			ris_q <= ris_d;
			dmacr_q <= dmacr_d;
			lpDiv_q <= lpDiv_d;
			lpCnt_q <= lpCnt_d;
			regRdata <= rdata_d;
			combined_irq_output <= irq_d;
			rx_dma_single_request <= rxS_d;
			rx_dma_burst_request <= rxB_d;
			txDmaSingleRequest <= txS_d;
			txDmaBurstRequest <= txB_d;
			infrared_lowpower_tick <= lpTick_d;
		end
	end

	// Fractional baud: period is integer part, plus one when the
	// sixty-fourths accumulator carries.
	always_comb begin
		logic [6:0] sum;
		sum = {1'b0, fracAcc_q} + {1'b0, divisor_fraction_part_q};
		tick_d = baudCnt_q == 16'h0000;
		baudCnt_d = baudCnt_q - 16'h0001;
		fracAcc_d = fracAcc_q;
		if (tick_d) begin
			baudCnt_d = (divisor_integer_part_q == 16'h0000) ? 16'h0000 :
				divisor_integer_part_q - 16'h0001 + {15'h0000, sum[6]};
			fracAcc_d = sum[5:0];
		end
		filt_d = filt_q;
		for (int i = 0; i < 5; i++) begin
			if (s2_q[i] == s3_q[i]) begin
				filt_d[i] = s3_q[i];
			end
		end
		rxF = filt_q[4];
		lineTick = tick_q && ctrl_q[`UIC_C_EN];
	end
	// Baud counter and pin synchronisers.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			baudCnt_q <= 16'h0000;
			fracAcc_q <= 6'h00;
			tick_q <= 1'b0;
			s1_q <= 5'h1F;
			s2_q <= 5'h1F;
			s3_q <= 5'h1F;
			filt_q <= 5'h1F;
		end else begin
			baudCnt_q <= baudCnt_d;
			fracAcc_q <= fracAcc_d;
			tick_q <= tick_d;
			s1_q <= {rxd, modemIn};
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
		end
	end

	// Serializer: start, data LSB first, parity, one or two stops.
	always_comb begin
		txSt_d = txSt_q;
		txTk_d = txTk_q;
		txBit_d = txBit_q;
		txSh_d = txSh_q;
		txStop2_d = txStop2_q;
		txPop = 1'b0;
		txd_d = 1'b1;
		case (txSt_q)
			uic_pkg::TX_IDLE: begin
				if (txOutValid && ctrl_q[`UIC_C_TXE] && lineTick) begin
					txPop = 1'b1;
					txSh_d = txOutData;
					txSt_d = uic_pkg::TX_START;
					txTk_d = 4'h0;
				end
			end
			uic_pkg::TX_START: txd_d = 1'b0;
			uic_pkg::TX_DATA: txd_d = txSh_q[txBit_q];
			uic_pkg::TX_PAR: txd_d = line_q[`UIC_L_EPS] ? ^txSh_q : ~^txSh_q;
			uic_pkg::TX_STOP: txd_d = 1'b1;
			default: txSt_d = uic_pkg::TX_IDLE;
		endcase
		if (txSt_q != uic_pkg::TX_IDLE && lineTick) begin
			txTk_d = txTk_q + 4'h1;
			if (txTk_q == 4'hF) begin
				case (txSt_q)
					uic_pkg::TX_START: begin
						txSt_d = uic_pkg::TX_DATA;
						txBit_d = 3'h0;
						txStop2_d = line_q[`UIC_L_STP2];
					end
					uic_pkg::TX_DATA: begin
						txBit_d = txBit_q + 3'h1;
						if (txBit_q == 3'h7) begin
							txSt_d = line_q[`UIC_L_PEN] ? uic_pkg::TX_PAR :
								uic_pkg::TX_STOP;
						end
					end
					uic_pkg::TX_PAR: txSt_d = uic_pkg::TX_STOP;
					default: begin
						txStop2_d = 1'b0;
						if (!txStop2_q) begin
							txSt_d = uic_pkg::TX_IDLE;
						end
					end
				endcase
			end
		end
		if (line_q[`UIC_L_BRK] && txSt_q == uic_pkg::TX_IDLE) begin
			txd_d = 1'b0;
		end
	end
	// Serializer registers.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			txSt_q <= uic_pkg::TX_IDLE;
			txTk_q <= 4'h0;
			txBit_q <= 3'h0;
			txSh_q <= 8'h00;
			txStop2_q <= 1'b0;
			txd <= 1'b1;
		end else begin
			txSt_q <= txSt_d;
			txTk_q <= txTk_d;
			txBit_q <= txBit_d;
			txSh_q <= txSh_d;
			txStop2_q <= txStop2_d;
			txd <= txd_d;
		end
	end

	// Deserializer: start bit checked at mid-bit, then sampled
	// every sixteen ticks; errors stored with the byte.
	always_comb begin
		rxSt_d = rxSt_q;
		rxTk_d = rxTk_q;
		rxBit_d = rxBit_q;
		rxSh_d = rxSh_q;
		rxPe_d = rxPe_q;
		ovrPend_d = ovrPend_q;
		rxArm_d = 1'b0;
		rxPush = 1'b0;
		// Break means the whole frame low: data, parity bit level and stop.
		rxEntry = {ovrPend_q, rxSh_q == 8'h00 && !rxF &&
			(!line_q[`UIC_L_PEN] || rxPe_q == !line_q[`UIC_L_EPS]),
			rxPe_q, !rxF, rxSh_q};
		if (lineTick) begin
			rxTk_d = rxTk_q + 4'h1;
		end
		case (rxSt_q)
			uic_pkg::RX_IDLE: begin
				rxTk_d = 4'h0;
				// A start needs the line seen idle first, so a low stop bit
				// or a break does not restart the receiver.
				rxArm_d = rxArm_q || rxF;
				if (!rxF && rxArm_q && ctrl_q[`UIC_C_RXE] &&
					lineTick) begin
					rxSt_d = uic_pkg::RX_START;
					rxArm_d = 1'b0;
				end
			end
			uic_pkg::RX_START: begin
				if (lineTick && rxTk_q == 4'h7) begin
					rxSt_d = rxF ? uic_pkg::RX_IDLE : uic_pkg::RX_DATA;
					rxTk_d = 4'h0;
					rxBit_d = 3'h0;
					rxPe_d = 1'b0;
				end
			end
			default: begin
				if (lineTick && rxTk_q == 4'hF) begin
					case (rxSt_q)
						uic_pkg::RX_DATA: begin
							rxSh_d = {rxF, rxSh_q[7:1]};
							rxBit_d = rxBit_q + 3'h1;
							if (rxBit_q == 3'h7) begin
								rxSt_d = line_q[`UIC_L_PEN] ? uic_pkg::RX_PAR :
									uic_pkg::RX_STOP;
							end
						end
						uic_pkg::RX_PAR: begin
							rxPe_d = rxF ^ ^rxSh_q ^ ~line_q[`UIC_L_EPS];
							rxSt_d = uic_pkg::RX_STOP;
						end
						default: begin
							rxSt_d = uic_pkg::RX_IDLE;
							rxPush = 1'b1;
							ovrPend_d = !rxInReady;
							if (rxInReady) begin
								ovrPend_d = 1'b0;
							end
						end
					endcase
				end
			end
		endcase
		// Idle timer restarts on any FIFO activity.
		rtCnt_d = rtCnt_q;
		if (rxPush || rxPop || rxCount == '0) begin
			rtCnt_d = 9'h000;
		end else if (lineTick && rtCnt_q != `UIC_TIMEOUT) begin
			rtCnt_d = rtCnt_q + 9'h001;
		end
	end
	// Deserializer registers.
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rxSt_q <= uic_pkg::RX_IDLE;
			rxTk_q <= 4'h0;
			rxBit_q <= 3'h0;
			rxSh_q <= 8'h00;
			rxPe_q <= 1'b0;
			ovrPend_q <= 1'b0;
			rxArm_q <= 1'b0;
			rtCnt_q <= 9'h000;
		end else begin
			rxSt_q <= rxSt_d;
			rxTk_q <= rxTk_d;
			rxBit_q <= rxBit_d;
			rxSh_q <= rxSh_d;
			rxPe_q <= rxPe_d;
			ovrPend_q <= ovrPend_d;
			rxArm_q <= rxArm_d;
			rtCnt_q <= rtCnt_d;
		end
	end

	// ========================================
	// Checks.
	property p_irq;
		@(posedge clk) disable iff (!reset_n)
		##1 combined_irq_output == |($past(ris_q) & $past(imsc_q));
	endproperty
	a_irq: assert property (p_irq) else $error("irq not OR of mis");
	property p_mis;
		@(posedge clk) disable iff (!reset_n)
		regRead && regIdx == `UIC_IDX_MIS |=>
			regRdata[10:0] == ($past(ris_q) & $past(imsc_q));
	endproperty
	a_mis: assert property (p_mis) else $error("mis read wrong");
	property p_clr;
		@(posedge clk) disable iff (!reset_n)
		regWrite && regIdx == `UIC_IDX_ICR && regWdata[`UIC_B_RX] &&
			!rxPush |=> !ris_q[`UIC_B_RX];
	endproperty
	a_clr: assert property (p_clr) else $error("clear failed");
	property p_keep;
		@(posedge clk) disable iff (!reset_n)
		regWrite && regIdx == `UIC_IDX_ICR && regWdata == 32'h00000000 &&
			!txInValid |=> (ris_q & $past(ris_q)) == $past(ris_q);
	endproperty
	a_keep: assert property (p_keep) else $error("zero cleared");
	property p_dmaerr;
		@(posedge clk) disable iff (!reset_n)
		dmacr_q[`UIC_D_ONERR] && |ris_q[`UIC_B_OE:`UIC_B_FE] |=>
			!rx_dma_single_request && !rx_dma_burst_request;
	endproperty
	a_dmaerr: assert property (p_dmaerr) else $error("dma on error");
	property p_txdma;
		@(posedge clk) disable iff (!reset_n)
		!dmacr_q[`UIC_D_TXE] |=> !txDmaSingleRequest && !txDmaBurstRequest;
	endproperty
	a_txdma: assert property (p_txdma) else $error("tx dma ungated");
	property p_start;
		@(posedge clk) disable iff (!reset_n)
		txSt_q == uic_pkg::TX_START |=> !txd;
	endproperty
	a_start: assert property (p_start) else $error("no start bit");
	property p_tick;
		@(posedge clk) disable iff (!reset_n)
		tick_q && divisor_integer_part_q == 16'h0002 &&
			divisor_fraction_part_q == 6'h00 && $stable(divisor_integer_part_q)
			|-> ##1 !tick_q ##1 tick_q;
	endproperty
	a_tick: assert property (p_tick) else $error("tick period");
	property p_rto;
		@(posedge clk) disable iff (!reset_n)
		rxCount != '0 && rtCnt_q == `UIC_TIMEOUT |=> ris_q[`UIC_B_RT];
	endproperty
	a_rto: assert property (p_rto) else $error("no rx timeout");
endmodule

// *** tb/uic_line_partner.sv ***
`timescale 1ns/100ps
// ========================================
// Remote serial transceiver at the far end of the line.
module uic_line_partner (
	input wire logic clk,
	input wire logic txd,
	input wire logic [7:0] bitClocks,
	input wire logic parityOn,
	output logic rxd
);
	logic [7:0] rxq[$];
	logic [7:0] shiftIn;
	int k;

	// The line idles at the mark level, as a pulled-up wire would.
	initial rxd = 1'b1;

	// Sends one frame; the caller picks the parity and stop levels.
	task automatic send(input logic [7:0] b, input logic addPar,
		input logic parBit, input logic stopBit);
		int i;
		@(negedge clk);
		rxd = 1'b0;
		repeat (bitClocks) @(negedge clk);
		for (i = 0; i < 8; i++) begin
			rxd = b[i];
			repeat (bitClocks) @(negedge clk);
		end
		if (addPar) begin
			rxd = parBit;
			repeat (bitClocks) @(negedge clk);
		end
		rxd = stopBit;
		repeat (bitClocks) @(negedge clk);
		rxd = 1'b1;
		repeat (bitClocks) @(negedge clk);
	endtask

	// Decodes device frames, sampling each bit but the parity bit in its middle.
	always begin
		@(negedge txd);
		repeat (bitClocks / 2) @(posedge clk);
		if (txd == 1'b0) begin
			for (k = 0; k < 8; k++) begin
				repeat (bitClocks) @(posedge clk);
				shiftIn[k] = txd;
			end
			if (parityOn) repeat (bitClocks) @(posedge clk);
			repeat (bitClocks) @(posedge clk);
			if (txd == 1'b1) rxq.push_back(shiftIn);
		end
	end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/100ps
`include "uic_cfg.svh"
// ========================================
// Self-checking bench for the transceiver core.
module tb_top;
	logic clk, reset_n, regWrite, regRead, rxd, txd, parityOn;
	logic irqOut, rxDmaSingle, rxDmaBurst, txDmaSingle, txDmaBurst, lpTick;
	logic [3:0] regIdx, modemIn;
	logic [7:0] bitClocks;
	logic [31:0] regWdata, regRdata;
	int mismatches, comparisons, i, w;

	uic_core #(.DEPTH(32)) uic_core_inst (.clk(clk), .reset_n(reset_n),
		.regIdx(regIdx), .regWrite(regWrite), .regRead(regRead),
		.regWdata(regWdata), .regRdata(regRdata), .rxd(rxd), .txd(txd),
		.modemIn(modemIn), .combined_irq_output(irqOut),
		.rx_dma_single_request(rxDmaSingle),
		.rx_dma_burst_request(rxDmaBurst),
		.txDmaSingleRequest(txDmaSingle), .txDmaBurstRequest(txDmaBurst),
		.infrared_lowpower_tick(lpTick));
	uic_line_partner uic_line_partner_inst (.clk(clk), .txd(txd),
		.bitClocks(bitClocks), .parityOn(parityOn), .rxd(rxd));

	// Free-running clock of 40 ns.
	initial clk = 1'b0;
	always #20 clk = ~clk;

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Compares a value and reports any difference at once.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string what);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	// Register write: one strobe cycle.
	task automatic wr(input logic [3:0] idx, input logic [31:0] d);
		@(negedge clk);
		regIdx = idx;
		regWdata = d;
		regWrite = 1'b1;
		@(negedge clk);
		regWrite = 0;
	endtask

	// Register read: data is registered one cycle after the strobe.
	task automatic rd(input logic [3:0] idx, output logic [31:0] d);
		@(negedge clk);
		regIdx = idx;
		regRead = 1'b1;
		@(negedge clk);
		regRead = 1'b0;
		@(negedge clk);
		d = regRdata;
	endtask

	// Reads a register and compares the masked bits.
	task automatic chkReg(input logic [3:0] idx, input logic [31:0] m,
		input logic [31:0] exp, input string what);
		logic [31:0] r;
		rd(idx, r);
		chk(r & m, exp, what);
	endtask

	// Waits, bounded, for the partner to hold n decoded bytes.
	task automatic waitQ(input int n);
		int c;
		c = 0;
		while (uic_line_partner_inst.rxq.size() < n && c < 20000) begin
			@(negedge clk);
			c++;
		end
	endtask

	// Receives one frame with parity, checks the DMA gate and the entry.
	task automatic rxCase(input logic [7:0] b, input logic pb,
		input logic sb, input logic [31:0] m, input logic [31:0] exp,
		input logic dmaExp);
		logic [31:0] r;
		uic_line_partner_inst.send(b, 1'b1, pb, sb);
		repeat (20) @(negedge clk);
		wr(`UIC_IDX_DMACR, 32'h0000_0005);
		repeat (2) @(negedge clk);
		chk({31'h0, rxDmaSingle}, {31'h0, dmaExp}, "rx dma gate");
		rd(`UIC_IDX_DATA, r);
		chk(r & m, exp, "rx entry");
		wr(`UIC_IDX_ICR, 32'h0000_07FF);
	endtask

	// Measures the start bit of the next frame in clocks.
	task automatic startWidth(output int wd);
		int n;
		n = 0;
		wd = 0;
		while (txd === 1'b1 && n < 5000) begin
			@(negedge clk);
			n++;
		end
		while (txd === 1'b0 && wd < 5000) begin
			@(negedge clk);
			wd++;
		end
	endtask

	// Watchdog against a hang.
	initial begin
		repeat (60000) @(posedge clk);
		mismatches++;
		$display("BAD t=%0t watchdog expired", $time);
		close_out();
	end

	// Main sequence of tests.
	initial begin
		{reset_n, regWrite, regRead, regIdx, parityOn} = 0;
		regWdata = 0;
		// Modem lines idle high, as the synchronisers assume after reset.
		modemIn = 4'hF;
		bitClocks = 8'h10;
		repeat (2) @(posedge clk);
		@(negedge clk);
		reset_n = 1'b1;
		chkReg(`UIC_IDX_IMSC, 32'h7FF, 32'h0, "imsc rst");
		chkReg(`UIC_IDX_RIS, 32'h7F0, 32'h0, "ris rst");
		chkReg(`UIC_IDX_MIS, 32'h7F0, 32'h0, "mis rst");
		chkReg(`UIC_IDX_DMACR, 32'h7, 32'h0, "dma rst");
		chk({31'h0, irqOut}, 32'h0, "irq rst");
		$display("test reset done");
		wr(`UIC_IDX_IMSC, 32'h7FF);
		chkReg(`UIC_IDX_IMSC, 32'h7FF, 32'h7FF, "imsc");
		wr(`UIC_IDX_IMSC, 32'h0);
		chkReg(`UIC_IDX_IMSC, 32'h7FF, 32'h0, "imsc");
		modemIn = 4'hE;
		repeat (8) @(negedge clk);
		chkReg(`UIC_IDX_RIS, 32'hF, 32'h1, "modem raw");
		chkReg(`UIC_IDX_MIS, 32'hF, 32'h0, "modem mis");
		wr(`UIC_IDX_IMSC, 32'h1);
		repeat (3) @(negedge clk);
		chk({31'h0, irqOut}, 32'h1, "irq on");
		wr(`UIC_IDX_ICR, 32'h0);
		chkReg(`UIC_IDX_RIS, 32'hF, 32'h1, "icr zero");
		wr(`UIC_IDX_ICR, 32'hF);
		repeat (3) @(negedge clk);
		chk({31'h0, irqOut}, 32'h0, "irq off");
		wr(`UIC_IDX_IMSC, 32'h0);
		$display("test interrupts done");
		wr(`UIC_IDX_LINE, 32'h10);
		wr(`UIC_IDX_CTRL, 32'h301);
		wr(`UIC_IDX_DATA, 32'hA5);
		waitQ(1);
		chk({24'h0, uic_line_partner_inst.rxq.pop_front()}, 32'hA5, "tx");
		repeat (20) @(negedge clk);
		chkReg(`UIC_IDX_RIS, 32'h20, 32'h20, "tx raw");
		chkReg(`UIC_IDX_MIS, 32'h20, 32'h0, "tx mis off");
		wr(`UIC_IDX_IMSC, 32'h20);
		chkReg(`UIC_IDX_MIS, 32'h20, 32'h20, "tx mis on");
		chk({31'h0, irqOut}, 32'h1, "irq tx");
		wr(`UIC_IDX_ICR, 32'h20);
		chkReg(`UIC_IDX_RIS, 32'h20, 32'h0, "tx clr");
		chk({31'h0, irqOut}, 32'h0, "irq tx off");
		wr(`UIC_IDX_IMSC, 32'h0);
		$display("test transmit done");
		wr(`UIC_IDX_CTRL, 32'h201);
		for (i = 0; i < 33; i++) wr(`UIC_IDX_DATA, i);
		chkReg(`UIC_IDX_FLAG, 32'h8, 32'h8, "tx full");
		wr(`UIC_IDX_DMACR, 32'h2);
		repeat (2) @(negedge clk);
		chk({31'h0, txDmaSingle}, 32'h0, "tx dma full");
		chk({31'h0, txDmaBurst}, 32'h0, "tx burst full");
		wr(`UIC_IDX_CTRL, 32'h301);
		waitQ(32);
		repeat (400) @(negedge clk);
		chk(uic_line_partner_inst.rxq.size(), 32'd32, "tx count");
		for (i = 0; i < 32; i++) begin
			chk({24'h0, uic_line_partner_inst.rxq.pop_front()}, i, "fifo");
		end
		chk({31'h0, txDmaSingle}, 32'h1, "tx dma on");
		chk({31'h0, txDmaBurst}, 32'h1, "tx burst on");
		wr(`UIC_IDX_DMACR, 32'h0);
		repeat (2) @(negedge clk);
		chk({31'h0, txDmaSingle}, 32'h0, "tx dma off");
		chk({31'h0, txDmaBurst}, 32'h0, "tx burst off");
		wr(`UIC_IDX_LINE, 32'h0);
		wr(`UIC_IDX_CTRL, 32'h201);
		wr(`UIC_IDX_DATA, 32'h5A);
		chkReg(`UIC_IDX_FLAG, 32'h8, 32'h8, "hold full");
		wr(`UIC_IDX_CTRL, 32'h301);
		waitQ(1);
		chk({24'h0, uic_line_partner_inst.rxq.pop_front()}, 32'h5A, "hold");
		$display("test fifo done");
		wr(`UIC_IDX_LINE, 32'h10);
		uic_line_partner_inst.send(8'h3C, 1'b0, 1'b0, 1'b1);
		repeat (20) @(negedge clk);
		chkReg(`UIC_IDX_RIS, 32'h50, 32'h10, "rx raw");
		wr(`UIC_IDX_DMACR, 32'h1);
		repeat (2) @(negedge clk);
		chk({31'h0, rxDmaSingle}, 32'h1, "rx dma on");
		chk({31'h0, rxDmaBurst}, 32'h0, "rx burst one");
		wr(`UIC_IDX_DMACR, 32'h0);
		repeat (2) @(negedge clk);
		chk({31'h0, rxDmaSingle}, 32'h0, "rx dma off");
		repeat (600) @(negedge clk);
		chkReg(`UIC_IDX_RIS, 32'h40, 32'h40, "timeout");
		chkReg(`UIC_IDX_DATA, 32'hFFF, 32'h03C, "rx data");
		wr(`UIC_IDX_ICR, 32'h7FF);
		wr(`UIC_IDX_LINE, 32'h12);
		rxCase(8'h3C, 1'b1, 1'b1, 32'hFFF, 32'h03C, 1'b1);
		rxCase(8'h3C, 1'b0, 1'b1, 32'hFFF, 32'h23C, 1'b0);
		rxCase(8'h3C, 1'b1, 1'b0, 32'hFFF, 32'h13C, 1'b0);
		rxCase(8'h00, 1'b0, 1'b0, 32'h400, 32'h400, 1'b0);
		wr(`UIC_IDX_DMACR, 32'h0);
		$display("test receive done");
		wr(`UIC_IDX_IBRD, 32'h2);
		wr(`UIC_IDX_LINE, 32'h10);
		bitClocks = 8'd32;
		wr(`UIC_IDX_DATA, 32'hFF);
		startWidth(w);
		chk(w, 32'd32, "bit width");
		waitQ(1);
		chk({24'h0, uic_line_partner_inst.rxq.pop_front()}, 32'hFF, "b1");
		wr(`UIC_IDX_FBRD, 32'd32);
		wr(`UIC_IDX_LINE, 32'h10);
		bitClocks = 8'd40;
		wr(`UIC_IDX_DATA, 32'hFF);
		startWidth(w);
		chk(w, 32'd40, "frac width");
		waitQ(1);
		chk({24'h0, uic_line_partner_inst.rxq.pop_front()}, 32'hFF, "b2");
		wr(`UIC_IDX_LPDIV, 32'h3);
		w = 0;
		repeat (40) begin
			@(negedge clk);
			w = w + lpTick;
		end
		chk(w, 32'd10, "lp ticks");
		$display("test baud done");
		close_out();
	end
endmodule
